// File: hw/ehp_pkg.sv
// Summary of operation
// - eight shared lines carry low address, then data, in both directions
// - shared line zero carries address bit zero and data bit zero
// - three input-only lines give address bits eight to ten: eleven-bit address
// - address on shared lines is captured using the address latch enable
// - read strobe low drives addressed byte onto shared lines, else released
// - write strobe stores the shared-line byte at the latched address
// - interrupt output is the OR of all internal interrupt sources
// - low master reset asynchronously returns all registers except the memory contents and its read register to default state
// - reset output active while master reset or bus reset is active
// - pull-up control drives supply level to attach, or floats to detach
package ehp_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int UPPER_W = 3;
  localparam int MEM_DEPTH = 2048;
  localparam int IRQ_SRC_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic RESET_OUT_INIT = 1'b1;
  localparam logic OE_N_INIT = 1'b1;
  localparam logic STROBE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_READ,
    PH_WRITE
  } ehp_phase_t;

  typedef struct packed {
    ehp_phase_t phase;
    logic [ADDR_W-1:0] addrLatch;
    logic alePrev;
    logic wrPrev;
    logic [DATA_W-1:0] rdData;
    logic adOeN;
    logic irq;
    logic resetOut;
    logic pullOeN;
    logic extMode;
    logic modeTaken;
  } ehp_state_t;
endpackage

// File: hw/ehp_xdata_ram.sv
`timescale 1ns/1ps
module ehp_xdata_ram
  import ehp_pkg::*;
(
  // clock
  input wire logic sysClk,
  input wire logic clkEn,
  // access
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // contents carry no reset, as a real block ram would not
  always_ff @(posedge sysClk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[addr] <= wrData;
      end
      rdData <= mem[addr];
    end
  end
endmodule

// File: hw/ehp_host_port.sv
`timescale 1ns/1ps
module ehp_host_port
  import ehp_pkg::*;
(
  // clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  // master reset pin and mode straps
  input wire logic masterResetN,
  input wire logic extCtrlModeSel,
  input wire logic testModeSel,
  // host shared address/data lines
  input wire logic [DATA_W-1:0] hostSharedAddrDataIn,
  output logic [DATA_W-1:0] hostSharedAddrDataOut,
  output logic hostSharedAddrDataOeN,
  // host address and strobes
  input wire logic [UPPER_W-1:0] hostUpperAddress,
  input wire logic hostAddrLatchEn,
  input wire logic hostReadStrobeN,
  input wire logic hostWriteStrobeN,
  // interrupt
  input wire logic [IRQ_SRC_W-1:0] irqSources,
  output logic hostIrqOut,
  // reset out and pull-up control
  input wire logic busResetActive,
  output logic resetOut,
  input wire logic pullupEnable,
  output logic pullupConnectOut,
  output logic pullupConnectOeN
);
  ehp_state_t st;
  ehp_state_t next_st;
  logic resetAll;
  logic aleFall;
  logic wrRise;
  logic ramWe;
  logic [DATA_W-1:0] ramQ;

  assign resetAll = rst | ~masterResetN;

  function automatic logic fallEdge(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  assign aleFall = fallEdge(st.alePrev, hostAddrLatchEn) & st.extMode;
  // store at strobe release, when data is surely settled
  assign wrRise = fallEdge(~st.wrPrev, ~hostWriteStrobeN);
  assign ramWe = clkEn & wrRise & st.extMode & hostReadStrobeN;

  ehp_xdata_ram u_ram (
    .sysClk(sys_clk),
    .clkEn(clkEn),
    .wrEn(ramWe),
    .addr(st.addrLatch),
    .wrData(hostSharedAddrDataIn),
    .rdData(ramQ)
  );

  always_comb begin
    next_st = st;
    next_st.alePrev = hostAddrLatchEn;
    next_st.wrPrev = hostWriteStrobeN;
    // mode straps taken once after reset release
    if (!st.modeTaken) begin
      next_st.modeTaken = 1'b1;
      next_st.extMode = extCtrlModeSel & ~testModeSel;
    end
    // upper address joins the shared byte
    if (aleFall) begin
      // line zero is address bit zero
      next_st.addrLatch = {hostUpperAddress, hostSharedAddrDataIn};
    end
    next_st.adOeN = ~(st.extMode & ~hostReadStrobeN);
    if (st.extMode & ~hostReadStrobeN) begin
      // data phase on the shared lines
      next_st.rdData = ramQ;
    end
    unique case (1'b1)
      hostAddrLatchEn: next_st.phase = PH_ADDR;
      !hostReadStrobeN: next_st.phase = PH_READ;
      !hostWriteStrobeN: next_st.phase = PH_WRITE;
      default: next_st.phase = PH_IDLE;
    endcase
    next_st.irq = |irqSources;
    next_st.resetOut = busResetActive;
    next_st.pullOeN = ~pullupEnable;
  end

  always_ff @(posedge sys_clk or posedge resetAll) begin
    if (resetAll) begin
      st.phase <= PH_IDLE;
      st.addrLatch <= ADDR_RESET;
      st.alePrev <= 1'b0;
      st.wrPrev <= STROBE_IDLE;
      st.rdData <= DATA_RESET;
      st.adOeN <= OE_N_INIT;
      st.irq <= 1'b0;
      st.resetOut <= RESET_OUT_INIT;
      st.pullOeN <= OE_N_INIT;
      st.extMode <= 1'b0;
      st.modeTaken <= 1'b0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign hostSharedAddrDataOut = st.rdData;
  assign hostSharedAddrDataOeN = st.adOeN;
  assign hostIrqOut = st.irq;
  assign resetOut = st.resetOut;
  // pin only ever pulls to supply; release is by the enable
  assign pullupConnectOut = 1'b1;
  assign pullupConnectOeN = st.pullOeN;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (resetAll);

  sequence aleFallSeq;
    clkEn && aleFall;
  endsequence

  sequence readHeldSeq;
    clkEn && st.extMode && !hostReadStrobeN;
  endsequence

  addr_latch_a: assert property (aleFallSeq |=>
    st.addrLatch == {$past(hostUpperAddress), $past(hostSharedAddrDataIn)})
    else $error("address not captured at latch enable fall");

  upper_addr_a: assert property (aleFallSeq |=>
    st.addrLatch[10:8] == $past(hostUpperAddress))
    else $error("upper address bits not latched");

  bit_zero_a: assert property (aleFallSeq |=>
    st.addrLatch[0] == $past(hostSharedAddrDataIn[0]))
    else $error("address bit zero wrong");

  read_drive_a: assert property (readHeldSeq ##1 readHeldSeq |=>
    !hostSharedAddrDataOeN && hostSharedAddrDataOut == $past(ramQ))
    else $error("read byte not driven");

  read_release_a: assert property (clkEn && hostReadStrobeN |=>
    hostSharedAddrDataOeN)
    else $error("shared lines not released");

  write_store_a: assert property (ramWe |->
    $rose(hostWriteStrobeN) && st.extMode)
    else $error("write outside strobe release");

  write_fall_a: assert property (clkEn && $fell(hostWriteStrobeN) |->
    !ramWe)
    else $error("write on strobe fall");

  irq_or_a: assert property (clkEn |=>
    hostIrqOut == (|$past(irqSources)))
    else $error("interrupt not or of sources");

  reset_out_a: assert property (clkEn |=>
    resetOut == $past(busResetActive))
    else $error("reset out does not follow bus reset");

  pullup_a: assert property (clkEn |=>
    pullupConnectOut && (pullupConnectOeN == !$past(pullupEnable)))
    else $error("pull-up control wrong");

  data_out_a: assert property (!hostSharedAddrDataOeN |->
    st.extMode && $past(!hostReadStrobeN))
    else $error("shared lines driven without read");

  // straps are read once per reset; a later change on them must not move the mode
  sequence strapTakeSeq;
    clkEn && !st.modeTaken;
  endsequence

  sequence modeOffSeq;
    clkEn && st.modeTaken && !st.extMode;
  endsequence

  sequence rdLowSeq;
    clkEn && !hostReadStrobeN;
  endsequence

  strap_take_a: assert property (strapTakeSeq |=>
    st.modeTaken && st.extMode == $past(extCtrlModeSel && !testModeSel))
    else $error("mode straps not taken after reset");

  strap_hold_a: assert property (st.modeTaken |=>
    st.modeTaken && $stable(st.extMode))
    else $error("mode changed after straps were taken");

  // a host strapped off must never see the lines driven, whatever it strobes
  mode_refuse_a: assert property (modeOffSeq ##1 rdLowSeq |=>
    hostSharedAddrDataOeN)
    else $error("shared lines driven outside external mode");

  read_lead_a: assert property (readHeldSeq |=>
    !hostSharedAddrDataOeN)
    else $error("shared lines not driven one cycle after read strobe");

  addr_hold_a: assert property (clkEn && !aleFall |=>
    $stable(st.addrLatch))
    else $error("address changed without latch enable fall");

  phase_read_a: assert property (clkEn && !hostReadStrobeN && !hostAddrLatchEn |=>
    st.phase == PH_READ)
    else $error("read strobe not seen as read phase");

  phase_write_a: assert property (clkEn && !hostWriteStrobeN && hostReadStrobeN &&
    !hostAddrLatchEn |=> st.phase == PH_WRITE)
    else $error("write strobe not seen as write phase");

  // own clock and no disable: this one has to look inside the reset itself
  reset_dflt_a: assert property (@(posedge sys_clk) disable iff (1'b0) resetAll |->
    resetOut && hostSharedAddrDataOeN && !hostIrqOut && pullupConnectOeN)
    else $error("outputs not at reset defaults");
endmodule

// File: bench/ehp_host_model.sv
`timescale 1ns/1ps
module ehp_host_model
  import ehp_pkg::*;
(
  // clock and wire level
  input wire logic sysClk,
  input wire logic [DATA_W-1:0] busLevel,
  // host drive
  output logic [DATA_W-1:0] adOut,
  output logic adDrive,
  output logic [UPPER_W-1:0] upper,
  output logic ale,
  output logic rdN,
  output logic wrN
);
  initial begin
    {adOut, adDrive, upper, ale, rdN, wrN} = 15'h0003;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sysClk);
    #1;
  endtask
  task automatic addrPhase(input logic [ADDR_W-1:0] a);
    step(1);
    {upper, adOut, adDrive, ale} = {a, 2'b11};
    step(1);
    ale = 1'b0;
    step(1);
  endtask
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addrPhase(a);
    {adOut, wrN} = {d, 1'b0};
    step(3);
    wrN = 1'b1;
    step(1);
    adDrive = 1'b0;
  endtask
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addrPhase(a);
    {adDrive, rdN} = 2'b00;
    step(4);
    d = busLevel;
    rdN = 1'b1;
    // device still drives one cycle after the strobe rises
    step(2);
  endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import ehp_pkg::*;
  logic sys_clk = 0, rst = 0, mrN = 1, busRst = 0, pullEn = 0;
  logic ce = 1, extSel = 1, testSel = 0;
  int drvCyc = 0;
  logic oeN, pOeN, pOut, irq, rOut, hDrv, ale, rdN, wrN;
  logic [7:0] irqSrc = 8'h00, adDev, hAd, bus, last = 8'h00;
  logic [2:0] hUp;
  int fails = 0, cmp_count = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  // released lines show a changing pattern, never the last value
  assign bus = !oeN ? adDev : hDrv ? hAd : ~last;
  always @(posedge sys_clk) last <= bus;
  ehp_host_port dut (.sys_clk(sys_clk), .rst(rst), .clkEn(ce), .masterResetN(mrN),
    .extCtrlModeSel(extSel), .testModeSel(testSel), .hostSharedAddrDataIn(bus),
    .hostSharedAddrDataOut(adDev), .hostSharedAddrDataOeN(oeN), .hostUpperAddress(hUp),
    .hostAddrLatchEn(ale), .hostReadStrobeN(rdN), .hostWriteStrobeN(wrN),
    .irqSources(irqSrc), .hostIrqOut(irq), .busResetActive(busRst), .resetOut(rOut),
    .pullupEnable(pullEn), .pullupConnectOut(pOut), .pullupConnectOeN(pOeN));
  ehp_host_model host (.sysClk(sys_clk), .busLevel(bus), .adOut(hAd), .adDrive(hDrv),
    .upper(hUp), .ale(ale), .rdN(rdN), .wrN(wrN));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // same low byte under two upper values catches a lost upper address
  task automatic t_mem;
    logic [ADDR_W-1:0] a[4] = '{11'h000, 11'h7ff, 11'h0a5, 11'h2a5};
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 4; i++) host.write(a[i], 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++) begin
      host.read(a[i], d);
      check("read data", d, 8'(8'h11 * (i + 1)));
    end
    check("data oe", oeN, 1'b1);
  endtask
  task automatic t_irq;
    for (int i = 0; i < 8; i++) begin
      irqSrc = 8'h01 << i;
      host.step(2);
      check("irq", irq, 1'b1);
    end
    irqSrc = 8'h00;
    host.step(2);
    check("irq", irq, 1'b0);
  endtask
  task automatic t_rst;
    busRst = 1;
    host.step(2);
    check("reset out", rOut, 1'b1);
    busRst = 0;
    irqSrc = 8'h80;
    host.step(2);
    check("reset out", rOut, 1'b0);
    mrN = 0;
    #1;
    check("reset out", rOut, 1'b1);
    check("irq", irq, 1'b0);
    host.step(2);
    {mrN, irqSrc} = 9'h100;
    host.step(3);
  endtask
  task automatic t_pull;
    pullEn = 1;
    host.step(2);
    check("pullup", {pOut, pOeN}, 2'b10);
    pullEn = 0;
    host.step(2);
    check("pullup", pOeN, 1'b1);
  endtask
  task automatic master_reset_n;
    mrN = 0;
    host.step(2);
    mrN = 1;
    host.step(3);
  endtask
  // a low enable must hold every flop, so new source levels must not show yet
  task automatic t_freeze;
    ce = 0;
    irqSrc = 8'h04;
    busRst = 1;
    host.step(3);
    check("frozen irq", irq, 1'b0);
    check("frozen reset out", rOut, 1'b0);
    ce = 1;
    host.step(2);
    check("irq", irq, 1'b1);
    check("reset out", rOut, 1'b1);
    {busRst, irqSrc} = 9'h000;
    host.step(2);
  endtask
  // every strap pair but external mode must leave the lines and memory alone
  task automatic t_mode;
    logic [1:0] strap[3] = '{2'b00, 2'b11, 2'b01};
    logic [DATA_W-1:0] d;
    int drv;
    for (int i = 0; i < 3; i++) begin
      {extSel, testSel} = strap[i];
      master_reset_n;
      host.write(11'h000, 8'hee);
      drv = drvCyc;
      host.read(11'h000, d);
      check("refused drive cycles", 16'(drvCyc - drv), 16'h0000);
    end
    {extSel, testSel} = 2'b10;
    master_reset_n;
    host.read(11'h000, d);
    check("kept data", d, 8'h11);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (!oeN) drvCyc++;
    if (cyc > 5000) begin
      fails++;
      wrap_up;
    end
  end
  // straps hold external mode through each reset unless a scenario refuses it
  initial begin
    #1 rst = 1;
    repeat (12) @(posedge sys_clk);
    #1 rst = 0;
    host.step(2);
    t_mem;
    t_irq;
    t_freeze;
    t_rst;
    t_mem;
    t_mode;
    t_pull;
    wrap_up;
  end
endmodule
